//--- verilog/ecpt_cfg.svh
`ifndef ECPT_CFG_SVH
`define ECPT_CFG_SVH

// channel count, narrow and joined counter widths
`define ECPT_NCH      8
`define ECPT_CW       8
`define ECPT_WIDE_W   16
`define ECPT_AW       8

// register byte offsets
`define ECPT_OFS_EN   8'h00
`define ECPT_OFS_POL  8'h01
`define ECPT_OFS_CTR  8'h02
`define ECPT_OFS_JOIN 8'h03
`define ECPT_OFS_LVL  8'h04
`define ECPT_OFS_PER  8'h08
`define ECPT_OFS_DUTY 8'h10
`define ECPT_OFS_CNT  8'h18

// reset values
`define ECPT_RST_EN   8'h00
`define ECPT_RST_POL  8'hff
`define ECPT_RST_CTR  8'h00
`define ECPT_RST_JOIN 4'h0
`define ECPT_RST_PER  8'hff
`define ECPT_RST_DUTY 8'h00

`endif

//--- verilog/ecpt_pkg.sv
`include "ecpt_cfg.svh"
`default_nettype none

package ecpt_pkg;

  // one register-port request, valid for a single cycle
  typedef struct packed
  {
    logic                wr;
    logic                rd;
    logic [`ECPT_AW-1:0] addr;
    logic [`ECPT_CW-1:0] wdata;
  } ecpt_req_t;

  // per-engine control bits
  typedef struct packed
  {
    logic en;
    logic pol;
    logic ctr;
  } ecpt_chcfg_t;

endpackage

`default_nettype wire

//--- verilog/ecpt_chan.sv
`include "ecpt_cfg.svh"
`default_nettype none

module ecpt_chan
#(
  parameter int W = `ECPT_WIDE_W
)
(
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  // settings
  input  wire ecpt_pkg::ecpt_chcfg_t cfg,
  input  wire logic [W-1:0]         per,
  input  wire logic [W-1:0]         duty,
  // state and waveform
  output logic                      out_q,
  output logic [W-1:0]              cnt_q
);
  import ecpt_pkg::*;

  logic [W-1:0] per_sh_q;
  logic [W-1:0] duty_sh_q;
  logic [W-1:0] cnt_d;
  logic [W-1:0] per_m1;
  logic         dn_q;
  logic         dn_d;
  logic         bnd;
  logic         out_d;

  // ***************************************************
  // period boundary and counter
  // ***************************************************
  assign per_m1 = per_sh_q - W'(1);
  // left: last count; centre: bottom of the down sweep
  assign bnd = (per_sh_q == '0) ||
               (cfg.ctr ? (dn_q && cnt_q == '0) : (cnt_q >= per_m1));

  always_comb
  begin
    cnt_d = cnt_q + W'(1);
    dn_d  = dn_q;
    if (!cfg.en || per_sh_q == '0)
    begin
      cnt_d = '0;
      dn_d  = 1'b0;
    end
    else if (!cfg.ctr)
    begin
      dn_d = 1'b0;
      if (bnd)
        cnt_d = '0;
    end
    else if (dn_q)
    begin
      // restart upward at 1 so zero is not visited twice
      cnt_d = bnd ? W'(1) : cnt_q - W'(1);
      dn_d  = !bnd;
    end
    else if (cnt_q >= per_sh_q)
    begin
      cnt_d = per_m1;
      dn_d  = 1'b1;
    end
  end

  // duty at or above period gives full in left alignment (centre needs duty above period), zero gives none
  assign out_d = cfg.en ? ((cnt_q < duty_sh_q) ~^ cfg.pol)
                        : !cfg.pol;

  // ***************************************************
  // registers
  // ***************************************************
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      cnt_q     <= '0;
      dn_q      <= 1'b0;
      per_sh_q  <= '0;
      duty_sh_q <= '0;
      out_q     <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      dn_q  <= dn_d;
      out_q <= out_d;
      // shadows move only at a boundary or while the channel is stopped, so no glitch
      if (!cfg.en || bnd)
      begin
        per_sh_q  <= per;
        duty_sh_q <= duty;
      end
    end
  end

  // ***************************************************
  // checks
  // ***************************************************
  a_left_wrap:
  assert property (@(posedge clk) disable iff (!rst_b)
    cfg.en && !cfg.ctr && per_sh_q != '0 && cnt_q == per_m1
    |=> cnt_q == '0)
  else $error("left counter did not wrap at period");

  a_left_step:
  assert property (@(posedge clk) disable iff (!rst_b)
    cfg.en && !cfg.ctr && !bnd |=> cnt_q == $past(cnt_q) + W'(1))
  else $error("left counter did not advance");

  a_centre_turn:
  assert property (@(posedge clk) disable iff (!rst_b)
    cfg.en && cfg.ctr && !dn_q && per_sh_q != '0 && cnt_q == per_sh_q
    |=> dn_q && cnt_q == $past(per_m1))
  else $error("centre counter did not turn at period");

  a_shadow_hold:
  assert property (@(posedge clk) disable iff (!rst_b)
    cfg.en && !bnd |=> $stable(per_sh_q) && $stable(duty_sh_q))
  else $error("period changed inside a period");

  a_duty_zero:
  assert property (@(posedge clk) disable iff (!rst_b)
    cfg.en && duty_sh_q == '0 |=> out_q == !$past(cfg.pol))
  else $error("zero duty drove the active level");

  a_duty_full:
  assert property (@(posedge clk) disable iff (!rst_b)
    cfg.en && !cfg.ctr && per_sh_q != '0 && duty_sh_q >= per_sh_q
    |=> out_q == $past(cfg.pol))
  else $error("full duty left the active level");

  a_idle_level:
  assert property (@(posedge clk) disable iff (!rst_b)
    !cfg.en |=> out_q == !$past(cfg.pol) && cnt_q == '0)
  else $error("stopped channel not at inactive level");

endmodule

`default_nettype wire

//--- verilog/ecpt_top.sv
// Implementation choices: strobed register access and the register offsets.
`include "ecpt_cfg.svh"
`default_nettype none

// Overview of operation
// - eight channels, own counter, period and duty
// - continuous output, duty from none to full
// - per-channel polarity selects active output level
// - per-channel left or centre alignment
// - adjacent pairs join into 16-bit channels

module ecpt_top
#(
  parameter int NCH = `ECPT_NCH,
  parameter int CW  = `ECPT_CW
)
(
  // clock and reset
  input  wire logic                clk,
  input  wire logic                rst_b,
  // register port
  input  wire ecpt_pkg::ecpt_req_t req,
  output logic [CW-1:0]            rdata_q,
  // waveform pins
  output logic [NCH-1:0]           pwm_out
);
  import ecpt_pkg::*;

  localparam int NP = NCH / 2;
  localparam int WW = 2 * CW;
  localparam int IW = $clog2(NCH);

  // ***************************************************
  // address decode
  // ***************************************************
  // one bank holds one byte per channel
  function automatic logic in_bank
  (
    input logic [`ECPT_AW-1:0] a,
    input logic [`ECPT_AW-1:0] base
  );
    in_bank = (a[`ECPT_AW-1:IW] == base[`ECPT_AW-1:IW]);
  endfunction

  // bank entry of one channel
  function automatic logic is_ch
  (
    input logic [IW-1:0] i,
    input int            r
  );
    is_ch = (i == IW'(r));
  endfunction

  logic [IW-1:0] idx;
  logic [CW-1:0] wval;
  logic          hit_en;
  logic          hit_pol;
  logic          hit_ctr;
  logic          hit_join;
  logic          hit_lvl;
  logic          hit_per;
  logic          hit_duty;
  logic          hit_cnt;
  logic          hit_any;
  logic          we_en;
  logic          we_pol;
  logic          we_ctr;
  logic          we_join;

  assign idx      = req.addr[IW-1:0];
  assign wval     = CW'(req.wdata);
  assign hit_en   = (req.addr == `ECPT_OFS_EN);
  assign hit_pol  = (req.addr == `ECPT_OFS_POL);
  assign hit_ctr  = (req.addr == `ECPT_OFS_CTR);
  assign hit_join = (req.addr == `ECPT_OFS_JOIN);
  assign hit_lvl  = (req.addr == `ECPT_OFS_LVL);
  assign hit_per  = in_bank(req.addr, `ECPT_OFS_PER);
  assign hit_duty = in_bank(req.addr, `ECPT_OFS_DUTY);
  assign hit_cnt  = in_bank(req.addr, `ECPT_OFS_CNT);

  // any mapped offset; anything else reads as zero
  assign hit_any  = hit_en | hit_pol | hit_ctr | hit_join | hit_lvl |
                    hit_per | hit_duty | hit_cnt;

  // write strobes; read-only offsets get none
  assign we_en    = req.wr & hit_en;
  assign we_pol   = req.wr & hit_pol;
  assign we_ctr   = req.wr & hit_ctr;
  assign we_join  = req.wr & hit_join;

  // ***************************************************
  // control registers
  // ***************************************************
  logic [NCH-1:0] en_q;
  logic [NCH-1:0] pol_q;
  logic [NCH-1:0] ctr_q;
  logic [NP-1:0]  join_q;
  logic [CW-1:0]  per_q  [NCH];
  logic [CW-1:0]  duty_q [NCH];

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      en_q <= NCH'(`ECPT_RST_EN);
    else if (we_en)
      en_q <= NCH'(wval);
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      pol_q <= NCH'(`ECPT_RST_POL);
    else if (we_pol)
      pol_q <= NCH'(wval);
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      ctr_q <= NCH'(`ECPT_RST_CTR);
    else if (we_ctr)
      ctr_q <= NCH'(wval);
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      join_q <= NP'(`ECPT_RST_JOIN);
    else if (we_join)
      join_q <= NP'(wval);
  end

  // period and duty banks, one byte per channel
  for (genvar r = 0; r < NCH; r++)
  begin : g_reg
    logic we_per;
    logic we_duty;

    assign we_per  = req.wr & hit_per & is_ch(idx, r);
    assign we_duty = req.wr & hit_duty & is_ch(idx, r);

    always_ff @(posedge clk)
    begin
      if (!rst_b)
      begin
        per_q[r]  <= CW'(`ECPT_RST_PER);
        duty_q[r] <= CW'(`ECPT_RST_DUTY);
      end
      else
      begin
        if (we_per)
          per_q[r] <= wval;
        if (we_duty)
          duty_q[r] <= wval;
      end
    end
  end

  // ***************************************************
  // channel engines
  // ***************************************************
  ecpt_chcfg_t   cfg_v  [NCH];
  logic [WW-1:0] per_v  [NCH];
  logic [WW-1:0] duty_v [NCH];
  logic [WW-1:0] cnt_w  [NCH];
  logic [CW-1:0] cnt_v  [NCH];

  for (genvar g = 0; g < NCH; g++)
  begin : g_ch
    localparam int P = g / 2;

    if (g % 2 == 1)
    begin : g_odd
      // odd channel holds the high byte of a joined pair
      assign per_v[g]  = join_q[P] ? {per_q[g], per_q[g-1]}
                                   : {{CW{1'b0}}, per_q[g]};
      assign duty_v[g] = join_q[P] ? {duty_q[g], duty_q[g-1]}
                                   : {{CW{1'b0}}, duty_q[g]};
      assign cfg_v[g]  = '{en: en_q[g], pol: pol_q[g], ctr: ctr_q[g]};
      assign cnt_v[g]  = join_q[P] ? cnt_w[g][WW-1:CW]
                                   : cnt_w[g][CW-1:0];
    end
    else
    begin : g_even
      assign per_v[g]  = {{CW{1'b0}}, per_q[g]};
      assign duty_v[g] = {{CW{1'b0}}, duty_q[g]};
      // even engine rests while its pair is joined
      assign cfg_v[g]  = '{en:  en_q[g] & ~join_q[P],
                           pol: pol_q[g],
                           ctr: ctr_q[g]};
      assign cnt_v[g]  = join_q[P] ? cnt_w[g+1][CW-1:0]
                                   : cnt_w[g][CW-1:0];

      a_join_quiet:
      assert property (@(posedge clk) disable iff (!rst_b)
        join_q[P] |=> pwm_out[g] == !$past(pol_q[g]))
      else $error("low half of a joined pair is not idle");
    end

    // narrow channels leave the upper period byte at zero,
    // so their counter never leaves eight bits
    ecpt_chan #(
      .W (WW)
    ) u_chan (
      .clk   (clk),
      .rst_b (rst_b),
      .cfg   (cfg_v[g]),
      .per   (per_v[g]),
      .duty  (duty_v[g]),
      .out_q (pwm_out[g]),
      .cnt_q (cnt_w[g])
    );
  end

  // ***************************************************
  // read path
  // ***************************************************
  logic [CW-1:0] rd_view;

  // unmapped offsets read as zero
  assign rd_view = hit_en   ? CW'(en_q)    :
                   hit_pol  ? CW'(pol_q)   :
                   hit_ctr  ? CW'(ctr_q)   :
                   hit_join ? CW'(join_q)  :
                   hit_lvl  ? CW'(pwm_out) :
                   hit_per  ? per_q[idx]   :
                   hit_duty ? duty_q[idx]  :
                   hit_cnt  ? cnt_v[idx]   :
                   '0;

  // data stand for one cycle only, zero otherwise
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      rdata_q <= '0;
    else if (req.rd)
      rdata_q <= rd_view;
    else
      rdata_q <= '0;
  end

  // ***************************************************
  // checks
  // ***************************************************
  a_en_readback:
  assert property (@(posedge clk) disable iff (!rst_b)
    req.rd && hit_en |=> rdata_q == $past(CW'(en_q)))
  else $error("enable readback mismatch");

  a_per_store:
  assert property (@(posedge clk) disable iff (!rst_b)
    req.wr && hit_per && idx == '0 |=> per_q[0] == $past(wval))
  else $error("period write not stored");

  a_pol_store:
  assert property (@(posedge clk) disable iff (!rst_b)
    req.wr && hit_pol ##1 !req.wr [*2] |-> pol_q == NCH'($past(wval, 2)))
  else $error("polarity write lost");

  a_rd_oneshot:
  assert property (@(posedge clk) disable iff (!rst_b)
    !req.rd |=> rdata_q == '0)
  else $error("read data stood beyond its cycle");

  a_en_store:
  assert property (@(posedge clk) disable iff (!rst_b)
    we_en |=> en_q == NCH'($past(wval)))
  else $error("enable write not stored");

  a_ctr_store:
  assert property (@(posedge clk) disable iff (!rst_b)
    we_ctr |=> ctr_q == NCH'($past(wval)))
  else $error("alignment write not stored");

  a_join_store:
  assert property (@(posedge clk) disable iff (!rst_b)
    we_join |=> join_q == NP'($past(wval)))
  else $error("join write not stored");

  a_duty_store:
  assert property (@(posedge clk) disable iff (!rst_b)
    req.wr && hit_duty |=> duty_q[$past(idx)] == $past(wval))
  else $error("duty write not stored");

  a_lvl_readback:
  assert property (@(posedge clk) disable iff (!rst_b)
    req.rd && hit_lvl |=> rdata_q == $past(CW'(pwm_out)))
  else $error("pin level readback mismatch");

  a_unmapped_zero:
  assert property (@(posedge clk) disable iff (!rst_b)
    req.rd && !hit_any |=> rdata_q == '0)
  else $error("unmapped read not zero");

  a_rd_no_write:
  assert property (@(posedge clk) disable iff (!rst_b)
    req.rd && !req.wr |=> $stable(en_q) && $stable(pol_q) &&
                          $stable(ctr_q) && $stable(join_q))
  else $error("read altered a control register");

  a_cnt_hi_read:
  assert property (@(posedge clk) disable iff (!rst_b)
    req.rd && hit_cnt && idx == IW'(NCH-1) && join_q[NP-1]
    |=> rdata_q == $past(cnt_w[NCH-1][WW-1:CW]))
  else $error("joined counter high byte misread");

  a_even_rest:
  assert property (@(posedge clk) disable iff (!rst_b)
    join_q[0] |=> cnt_w[0] == '0)
  else $error("low engine of a joined pair runs");

endmodule

`default_nettype wire

//--- tb/ecpt_load.sv
`default_nettype none

// ****************
// load on the pins
// ****************
// counts the cycles each pin sits high since the last clear
module ecpt_load
(
  // clock and control
  input  wire logic         clk,
  input  wire logic         clr,
  // waveform pins
  input  wire logic [7:0]   pin,
  // high-time totals
  output logic [7:0][15:0]  hi_cnt
);
  timeunit 1ns;
  timeprecision 1ps;

  always_ff @(posedge clk)
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (clr)
        hi_cnt[i] <= 16'h0000;
      else
        hi_cnt[i] <= hi_cnt[i] + 16'(pin[i]);
    end
  end
endmodule

`default_nettype wire

//--- tb/eight_channel_pwm_timer_tb_top.sv
`include "ecpt_cfg.svh"
`default_nettype none

module eight_channel_pwm_timer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ecpt_pkg::*;

  typedef struct packed
  {
    logic       wr;
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] e;
  } ecpt_row_t;

  // reads of reset values, then write and read back
  localparam ecpt_row_t rows [15] = '{
    {1'b0, 8'h00, 8'h00, 8'h00}, {1'b0, 8'h01, 8'h00, 8'hff},
    {1'b0, 8'h02, 8'h00, 8'h00}, {1'b0, 8'h03, 8'h00, 8'h00},
    {1'b0, 8'h04, 8'h00, 8'h00}, {1'b0, 8'h0b, 8'h00, 8'hff},
    {1'b0, 8'h17, 8'h00, 8'h00}, {1'b0, 8'h1c, 8'h00, 8'h00},
    {1'b0, 8'h20, 8'h00, 8'h00}, {1'b0, 8'hff, 8'h00, 8'h00},
    {1'b1, 8'h03, 8'hff, 8'h0f}, {1'b1, 8'h20, 8'h55, 8'h00},
    {1'b1, 8'h1a, 8'h33, 8'h00}, {1'b1, 8'h0d, 8'h81, 8'h81},
    {1'b1, 8'h12, 8'h7e, 8'h7e}};

  // ch3 and ch5 active low, ch4 centred, pair 7:6 joined
  localparam logic [15:0] setup [18] = '{
    16'h01d7, 16'h0210, 16'h0308, 16'h0804, 16'h0904, 16'h0a04,
    16'h0b04, 16'h0c04, 16'h1002, 16'h1100, 16'h1204, 16'h1301,
    16'h1402, 16'h0f02, 16'h0e00, 16'h1701, 16'h1680, 16'h009f};

  logic            clk = 1'b0;
  logic            rst_b;
  logic            clr;
  ecpt_req_t       req;
  logic [7:0]      rdata_q;
  logic [7:0]      pwm_out;
  logic [7:0][15:0] hi_cnt;
  logic [15:0]     exp_hi [8];
  int              err_count = 0;
  int              checked = 0;

  always #5 clk = ~clk;

  ecpt_top dut
  (
    .clk     (clk),
    .rst_b   (rst_b),
    .req     (req),
    .rdata_q (rdata_q),
    .pwm_out (pwm_out)
  );

  ecpt_load load
  (
    .clk    (clk),
    .clr    (clr),
    .pin    (pwm_out),
    .hi_cnt (hi_cnt)
  );

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    req <= '0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    req <= '0;
    #1 chk(16'(rdata_q), 16'(e));
    @(posedge clk);
    #1 chk(16'(rdata_q), 16'h0000);
  endtask

  // window spans whole periods of every channel, so phase drops out
  task automatic measure;
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (512) @(posedge clk);
    #1;
    for (int i = 0; i < 8; i++)
      chk(hi_cnt[i], exp_hi[i]);
  endtask

  task tally_and_finish;
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    err_count++;
    tally_and_finish;
  end

  initial
  begin
    rst_b = 1'b0;
    req = '0;
    clr = 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    #1 chk(16'(pwm_out), 16'h0000);
    foreach (rows[i])
    begin
      if (rows[i].wr)
        wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e);
    end
    foreach (setup[i])
      wr(setup[i][15:8], setup[i][7:0]);
    @(posedge clk);
    for (int k = 0; k < 8; k++)
    begin
      #1 chk(16'(pwm_out[0]), 16'(k % 4 < 2));
      @(posedge clk);
    end
    exp_hi = '{16'd256, 16'd0, 16'd512, 16'd384,
               16'd192, 16'd512, 16'd0, 16'd384};
    measure;
    // new duty lands only at a boundary, then holds
    wr(8'h10, 8'h03);
    // old duty still shapes the running period
    repeat (2) @(posedge clk);
    #1 chk(16'(pwm_out[0]), 16'h0000);
    repeat (4) @(posedge clk);
    #1 chk(16'(pwm_out[0]), 16'h0001);
    exp_hi[0] = 16'd384;
    measure;
    @(posedge clk);
    rst_b <= 1'b0;
    @(posedge clk);
    rst_b <= 1'b1;
    #1 chk(16'(pwm_out), 16'h0000);
    rd(8'h00, 8'h00);
    tally_and_finish;
  end
endmodule

`default_nettype wire
